// >>> dv/secure_region_access_control_tb.sv
// self-checking bench for the secure region access controller
`timescale 1ns/1ns
module secure_region_access_control_tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hung;
   logic embedded_busy_pin, accel_program_input, region_active;
   logic bank0_blocked, dq_oe;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q, seed_v;
   logic [15:0] dq_out, v;
   logic [7:0] a;
   typedef struct {logic [31:0] v; logic [31:0] m; logic e;} srac_note_t;
   srac_note_t q_exp[$];
   int n_errors, checks;
   srac_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .embedded_busy_pin(embedded_busy_pin),
      .accel_program_input(accel_program_input),
      .region_active(region_active), .bank0_blocked(bank0_blocked),
      .dq_out(dq_out), .dq_oe(dq_oe));
   srac_host u_host (.pclk(pclk), .pready(pready), .prdata(prdata),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .hung(hung));
   task close_out;
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task cmp_rd(input srac_note_t x);
      checks++;
      if ((prdata & x.m) !== (x.v & x.m) || pslverr !== x.e) begin
         n_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, prdata, x.v);
      end
   endtask
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && q_exp.size() > 0) begin
         cmp_rd(q_exp.pop_front());
      end
   end
   task acc(input logic w, input logic [11:0] ad, input logic [31:0] d,
      input logic [31:0] ev, input logic [31:0] m, input logic e);
      q_exp.push_back('{ev, m, e});
      u_host.xfer(w, ad, d, q);
      if (hung) begin
         n_errors++;
         close_out();
      end
   endtask
   task wr(input logic [11:0] ad, input logic [31:0] d);
      acc(1'b1, ad, d, 32'h0, 32'h0, 1'b0);
   endtask
   task rd(input logic [11:0] ad, input logic [31:0] ev, input logic [31:0] m);
      acc(1'b0, ad, 32'h0, ev, m, 1'b0);
   endtask
   task cmd(input logic [11:0] ad, input logic [15:0] d);
      wr(12'h000, {4'h0, ad, d});
   endtask
   task seq(input logic [15:0] c);
      cmd(12'h555, 16'h00aa);
      cmd(12'h2aa, 16'h0055);
      cmd(12'h555, c);
   endtask
   task idle;
      int n;
      n = 0;
      q = 32'h2;
      while (q[1] !== 1'b0 && n < 300) begin
         rd(12'h00c, 32'h0, 32'h0);
         n++;
      end
      if (n == 300) begin
         n_errors++;
         close_out();
      end
   endtask
   task cmp_pin(input logic [15:0] ev);
      checks++;
      if (dq_oe !== 1'b1 || dq_out !== ev) begin
         n_errors++;
         $display("[FAIL] %0t pin data %h exp %h", $time, dq_out, ev);
      end
   endtask
   task refuse(input logic [31:0] c, input logic [7:0] ad);
      wr(12'h010, c);
      seq(16'h00a0);
      cmd({4'h0, ad}, 16'h0000);
      idle();
      rd(12'h00c, 32'h10, 32'h10);
      wr(12'h00c, 32'h10);
   endtask
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   initial begin
      #400000;
      n_errors++;
      close_out();
   end
   initial begin
      presetn = 1'b0;
      embedded_busy_pin = 1'b0;
      accel_program_input = 1'b0;
      seed_v = $urandom(32'ha60f);
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(12'h00c, 32'h0, 32'h1f);
      rd(12'h014, 32'h80, 32'hc0);
      acc(1'b0, 12'h018, 32'h0, 32'h0, 32'h0, 1'b1);
      cmd(12'h555, 16'h00aa);
      cmd(12'h2aa, 16'h0055);
      cmd(12'h2aa, 16'h0088);
      rd(12'h00c, 32'h0, 32'h1);
      seq(16'h0088);
      rd(12'h00c, 32'h9, 32'h9);
      embedded_busy_pin <= 1'b1;
      repeat (2) @(posedge pclk);
      rd(12'h008, 32'h0, 32'hffff);
      embedded_busy_pin <= 1'b0;
      a = 8'h80 | 8'($urandom);
      v = 16'($urandom);
      seq(16'h00a0);
      cmd({4'h0, a}, v);
      idle();
      wr(12'h004, {24'h0, a});
      rd(12'h008, {16'h0, v}, 32'hffff);
      cmp_pin(v);
      seq(16'h00a0);
      cmd(12'h010, 16'h0000);
      idle();
      rd(12'h00c, 32'h10, 32'h10);
      wr(12'h00c, 32'h10);
      wr(12'h004, 32'h100);
      rd(12'h008, 32'hffff, 32'hffff);
      wr(12'h010, 32'h2);
      wr(12'h004, {24'h0, a});
      repeat (256) rd(12'h008, 32'h0, 32'h0);
      rd(12'h008, {16'h0, v}, 32'hffff);
      accel_program_input <= 1'b1;
      repeat (2) @(posedge pclk);
      refuse(32'h4, a ^ 8'h02);
      accel_program_input <= 1'b0;
      refuse(32'h8, a ^ 8'h02);
      wr(12'h004, {24'h0, a ^ 8'h02});
      rd(12'h008, 32'hffff, 32'hffff);
      wr(12'h010, 32'h1);
      rd(12'h014, 32'hc0, 32'hc0);
      seq(16'h00a0);
      cmd({4'h0, a ^ 8'h01}, 16'h0000);
      idle();
      rd(12'h00c, 32'h11, 32'h11);
      wr(12'h004, {24'h0, a ^ 8'h01});
      rd(12'h008, 32'hffff, 32'hffff);
      seq(16'h0090);
      cmd(12'h3c1, 16'h0000);
      rd(12'h00c, 32'h0, 32'h9);
      seq(16'h0088);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(12'h00c, 32'h0, 32'hb);
      rd(12'h014, 32'hc0, 32'hc0);
      seq(16'h0088);
      rd(12'h00c, 32'h9, 32'h9);
      if (q_exp.size() != 0) begin
         n_errors++;
      end
      close_out();
   end
endmodule

// >>> dv/srac_checker.sv
// port assertions for the secure region access controller
`timescale 1ns/1ns
module srac_checker (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire embedded_busy_pin,
   input wire accel_program_input,
   input wire region_active,
   input wire bank0_blocked,
   input wire [15:0] dq_out,
   input wire dq_oe
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire cmd_wr = psel && penable && pwrite && paddr == 12'h000;
   a_bank0_tracks: assert property (bank0_blocked == region_active)
      else $error("bank0 block differs from region state");
   // region_active trails the command edge by two register stages
   a_entry_cause: assert property ($rose(region_active) |->
      $past(cmd_wr && pwdata[27:0] == 28'h5550088, 2))
      else $error("region entered without entry cycle");
   a_exit_cause: assert property ($fell(region_active) |->
      $past(cmd_wr && pwdata[15:0] == 16'h0000, 2))
      else $error("region left without final exit cycle");
   a_busy_hides: assert property (embedded_busy_pin [*4] |-> !dq_oe)
      else $error("region data driven while embedded work runs");
   a_oe_in_region: assert property (dq_oe |-> region_active)
      else $error("region data driven outside region mode");
   a_ready_prompt: assert property (psel && penable && !$past(penable)
      |-> pready)
      else $error("no ready in first access cycle");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_err_unmapped: assert property (pready && paddr > 12'h014 |-> pslverr)
      else $error("unmapped access without error");
   c_entry: cover property ($rose(region_active));
   c_exit: cover property ($fell(region_active));
   c_err: cover property (pslverr);
endmodule
bind srac_top srac_checker u_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .embedded_busy_pin(embedded_busy_pin),
   .accel_program_input(accel_program_input),
   .region_active(region_active), .bank0_blocked(bank0_blocked),
   .dq_out(dq_out), .dq_oe(dq_oe));

// >>> dv/srac_host.sv
// apb host model issuing command and register cycles
`timescale 1ns/1ns
module srac_host (
   input wire pclk,
   input wire pready,
   input wire [31:0] prdata,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   output logic hung
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      hung = 1'b0;
   end
   // caller enters just after a rising edge
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      hung = (pready !== 1'b1);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      // released lines must not keep showing the old request
      paddr <= ~a;
      pwdata <= ~d;
      @(posedge pclk);
   endtask
endmodule

// >>> hdl/srac_mem.v
// 256 word secure region storage with one program port
`timescale 1ns/1ns
`include "srac_defines.vh"
module srac_mem (
   input wire clk,
   input wire we,
   input wire [7:0] waddr,
   input wire [15:0] wdata,
   input wire [7:0] raddr,
   output wire [15:0] rdata
);
   reg [15:0] mem_q [0:`SRAC_REGION_WORDS-1];
   integer i;
   // erased at start; factory half content is loaded by production test
   initial begin
      for (i = 0; i < `SRAC_REGION_WORDS; i = i + 1) begin
         mem_q[i] = `SRAC_ERASED_WORD;
      end
   end
   always @(posedge clk) begin
      if (we) begin
         mem_q[waddr] <= mem_q[waddr] & wdata;
      end
   end
   assign rdata = mem_q[raddr];
endmodule

// >>> hdl/srac_sync.v
// two flop synchroniser for a pin level
`timescale 1ns/1ns
module srac_sync (
   input wire clk,
   input wire rst_n,
   input wire din,
   output wire dout
);
   reg meta_q;
   reg sync_q;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= din;
         sync_q <= meta_q;
      end
   end
   assign dout = sync_q;
endmodule

// >>> hdl/srac_top.v
// secure region access controller with apb command port
// Summary of operation
// - region of 256 words; low 128 factory, high 128 customer.
// - apb reads past the 256-word range return invalid data; dq_out drives the word at the low 8 address bits.
// - autoselect offset 03h bit 7 reports factory lock, always 1.
// - bit 6 reports customer lock; 0 until locked, then stuck 1.
// - while active, only bank 0 is blocked for simultaneous work.
// - after power-up or reset accesses go to the normal array.
// - secure reads served in asynchronous and burst read modes.
// - burst reads inside the region wrap word offset FFh to 00h.
// - while active, lowest sector maps to region; others read invalid data over apb, but dq_out still drives region words.
// - no region access while an embedded program or erase runs.
// - customer half programs and locks once; lock is permanent.
// - accel program and unlock bypass refused during customer program.
// - entry is AA at 555h, 55 at 2AAh, 88 at 555h.
// - exit is AA, 55, 90 at 555h, then 0000 anywhere.
// - program is AA, 55, A0 at 555h, then address and data.
// - region mode persists until exit sequence, reset or power loss.
// - reset aborts, tristates outputs, clears config, ignores commands.
// - program to a protected area is ignored; back to read mode.
`timescale 1ns/1ns
`include "srac_defines.vh"
module srac_top (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire embedded_busy_pin,
   input wire accel_program_input,
   output reg region_active,
   output reg bank0_blocked,
   output reg [15:0] dq_out,
   output reg dq_oe
);
   localparam S_IDLE = 3'd0;
   localparam S_UNL1 = 3'd1;
   localparam S_UNL2 = 3'd2;
   localparam S_PROG = 3'd3;
   localparam S_EXIT = 3'd4;
   localparam S_BUSY = 3'd5;

   reg [2:0] state_q;
   reg active_q;
   reg cust_lock_q;
   reg reject_q;
   reg burst_q;
   reg accel_req_q;
   reg bypass_req_q;
   reg [23:0] addr_q;
   reg [7:0] burst_ptr_q;
   reg [9:0] busy_cnt_q;
   reg [7:0] prog_addr_q;
   reg [15:0] prog_data_q;
   reg prog_we_q;
   wire emb_busy;
   wire [15:0] mem_rdata;
   wire wr_acc;
   wire rd_acc;
   wire [15:0] wd;
   wire [11:0] cmd_addr;
   wire accel_pin;

   assign wr_acc = psel & penable & pwrite;
   assign rd_acc = psel & penable & ~pwrite;
   assign wd = pwdata[15:0];
   assign cmd_addr = pwdata[27:16];

   // a pin from the flash core's embedded algorithm engine
   srac_sync u_busy_sync (
      .clk(pclk),
      .rst_n(presetn),
      .din(embedded_busy_pin),
      .dout(emb_busy)
   );

   // the accelerate-voltage level is a pin too; sync it the same way
   srac_sync u_accel_sync (
      .clk(pclk),
      .rst_n(presetn),
      .din(accel_program_input),
      .dout(accel_pin)
   );

   srac_mem u_mem (
      .clk(pclk),
      .we(prog_we_q),
      .waddr(prog_addr_q),
      .wdata(prog_data_q),
      .raddr(burst_ptr_q),
      .rdata(mem_rdata)
   );

   function is_cycle;
      input [11:0] a;
      input [15:0] d;
      input [11:0] ea;
      input [15:0] ed;
      begin
         is_cycle = (a == ea) && (d == ed);
      end
   endfunction

   // region read: in sector 0 and within 256 words, else invalid
   function [15:0] region_word;
      input [23:0] a;
      input [15:0] m;
      begin
         if (a[23:`SRAC_SECTOR_BITS] != 16'h0000) begin
            region_word = `SRAC_INVALID_DATA;
         end else begin
            region_word = m;
         end
      end
   endfunction

   wire cmd_wr;
   wire prog_bad;
   wire lock_wr;
   // whole program cycle count; the counter takes its low bits
   localparam integer PROG_CNT = `SRAC_PROG_CYCLES;
   assign cmd_wr = wr_acc && (paddr == `SRAC_REG_CMD);
   // factory half, a locked customer half and the refused modes
   assign prog_bad = cust_lock_q || !cmd_addr[`SRAC_HALF_BIT] ||
      cmd_addr[11:8] != 4'h0 || emb_busy || accel_req_q || bypass_req_q;
   // writes are ignored while reset is low, so no lock lands then
   assign lock_wr = presetn && wr_acc && paddr == `SRAC_REG_CTRL &&
      active_q && pwdata[`SRAC_CTRL_LOCK] && state_q != S_BUSY;

   // the lock is a nonvolatile bit: a hardware reset must leave it set
   initial begin
      cust_lock_q = 1'b0;
   end
   always @(posedge pclk) begin
      if (lock_wr) begin
         cust_lock_q <= 1'b1;
      end
   end

   // command sequencer
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= S_IDLE;
         active_q <= 1'b0;
         reject_q <= 1'b0;
         prog_we_q <= 1'b0;
         prog_addr_q <= 8'h00;
         prog_data_q <= 16'h0000;
         busy_cnt_q <= 10'h000;
      end else begin
         prog_we_q <= 1'b0;
         case (state_q)
         S_IDLE: begin
            if (cmd_wr) begin
               if (is_cycle(cmd_addr, wd, `SRAC_UNLOCK1_ADDR,
                     `SRAC_UNLOCK1_DATA)) begin
                  state_q <= S_UNL1;
               end
            end
         end
         S_UNL1: begin
            if (cmd_wr) begin
               if (is_cycle(cmd_addr, wd, `SRAC_UNLOCK2_ADDR,
                     `SRAC_UNLOCK2_DATA)) begin
                  state_q <= S_UNL2;
               end else begin
                  state_q <= S_IDLE;
               end
            end
         end
         S_UNL2: begin
            if (cmd_wr) begin
               state_q <= S_IDLE;
               if (is_cycle(cmd_addr, wd, `SRAC_UNLOCK1_ADDR,
                     `SRAC_ENTRY_DATA) && !emb_busy) begin
                  active_q <= 1'b1;
               end else if (active_q && is_cycle(cmd_addr, wd,
                     `SRAC_UNLOCK1_ADDR, `SRAC_EXIT_DATA)) begin
                  state_q <= S_EXIT;
               end else if (active_q && is_cycle(cmd_addr, wd,
                     `SRAC_UNLOCK1_ADDR, `SRAC_PROG_DATA)) begin
                  state_q <= S_PROG;
               end
            end
         end
         S_EXIT: begin
            if (cmd_wr) begin
               state_q <= S_IDLE;
               if (wd == `SRAC_EXIT_FINAL_DATA) begin
                  active_q <= 1'b0;
               end
            end
         end
         S_PROG: begin
            if (cmd_wr) begin
               if (prog_bad) begin
                  state_q <= S_IDLE;
                  reject_q <= 1'b1;
               end else begin
                  prog_addr_q <= cmd_addr[7:0];
                  prog_data_q <= wd;
                  prog_we_q <= 1'b1;
                  busy_cnt_q <= PROG_CNT[9:0];
                  state_q <= S_BUSY;
               end
            end
         end
         S_BUSY: begin
            // commands are ignored while the word programs
            if (busy_cnt_q == 10'h001) begin
               state_q <= S_IDLE;
            end
            busy_cnt_q <= busy_cnt_q - 10'h001;
         end
         default: state_q <= S_IDLE;
         endcase
         // a refusal wins over a clear written in the same cycle
         if (state_q == S_PROG && cmd_wr && prog_bad) begin
            reject_q <= 1'b1;
         end else if (wr_acc && paddr == `SRAC_REG_STATUS &&
               pwdata[`SRAC_ST_REJECT]) begin
            reject_q <= 1'b0;
         end
      end
   end

   // configuration and read pointer
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         burst_q <= 1'b0;
         accel_req_q <= 1'b0;
         bypass_req_q <= 1'b0;
         addr_q <= 24'h000000;
         burst_ptr_q <= 8'h00;
      end else begin
         if (wr_acc && paddr == `SRAC_REG_CTRL) begin
            burst_q <= pwdata[`SRAC_CTRL_BURST];
            accel_req_q <= pwdata[`SRAC_CTRL_ACCEL] & accel_pin;
            bypass_req_q <= pwdata[`SRAC_CTRL_BYPASS];
         end
         if (wr_acc && paddr == `SRAC_REG_ADDR) begin
            addr_q <= pwdata[23:0];
            burst_ptr_q <= pwdata[7:0];
         end else if (rd_acc && paddr == `SRAC_REG_RDATA && burst_q) begin
            burst_ptr_q <= burst_ptr_q + 8'h01;
         end
      end
   end

   // apb slave, single cycle access phase
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
         if (psel && !penable) begin
            case (paddr)
            `SRAC_REG_CMD, `SRAC_REG_ADDR: prdata <= {8'h00, addr_q};
            `SRAC_REG_CTRL:
               prdata <= {28'h0000000, bypass_req_q, accel_req_q,
                  burst_q, cust_lock_q};
            `SRAC_REG_RDATA: begin
               if (!active_q || emb_busy) begin
                  prdata <= 32'h00000000; // array side
               end else begin
                  prdata <= {16'h0000, region_word({addr_q[23:8],
                     burst_ptr_q}, mem_rdata)};
               end
            end
            `SRAC_REG_STATUS:
               prdata <= {27'h0000000, reject_q, active_q, cust_lock_q,
                  (state_q == S_BUSY), active_q};
            `SRAC_REG_AUTOSEL: begin
               prdata[`SRAC_FACTORY_LOCK_BIT] <= 1'b1;
               prdata[`SRAC_CUSTOMER_LOCK_BIT] <= cust_lock_q;
            end
            default: pslverr <= 1'b1;
            endcase
         end
      end
   end

   // pin side status and data drive
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         region_active <= 1'b0;
         bank0_blocked <= 1'b0;
         dq_out <= 16'h0000;
         dq_oe <= 1'b0;
      end else begin
         region_active <= active_q;
         bank0_blocked <= active_q;
         dq_out <= mem_rdata;
         dq_oe <= active_q & ~emb_busy;
      end
   end
endmodule

// >>> inc/srac_defines.vh
// constants for the secure region access controller
`ifndef SRAC_DEFINES_VH
`define SRAC_DEFINES_VH
`define SRAC_UNLOCK1_ADDR 12'h555
`define SRAC_UNLOCK2_ADDR 12'h2aa
`define SRAC_UNLOCK1_DATA 16'h00aa
`define SRAC_UNLOCK2_DATA 16'h0055
`define SRAC_ENTRY_DATA 16'h0088
`define SRAC_EXIT_DATA 16'h0090
`define SRAC_EXIT_FINAL_DATA 16'h0000
`define SRAC_PROG_DATA 16'h00a0
`define SRAC_REGION_WORDS 256
`define SRAC_HALF_BIT 7
`define SRAC_INVALID_DATA 16'hffff
`define SRAC_ERASED_WORD 16'hffff
`define SRAC_AUTOSEL_LOCK 8'h03
`define SRAC_FACTORY_LOCK_BIT 7
`define SRAC_CUSTOMER_LOCK_BIT 6
`define SRAC_SECTOR_BITS 8
`define SRAC_PROG_TIME_NS 1000
`define SRAC_CLK_NS 8
`define SRAC_PROG_CYCLES ((`SRAC_PROG_TIME_NS + `SRAC_CLK_NS - 1) / `SRAC_CLK_NS)
// apb register map
`define SRAC_REG_CMD 12'h000
`define SRAC_REG_ADDR 12'h004
`define SRAC_REG_RDATA 12'h008
`define SRAC_REG_STATUS 12'h00c
`define SRAC_REG_CTRL 12'h010
`define SRAC_REG_AUTOSEL 12'h014
`define SRAC_ST_ACTIVE 0
`define SRAC_ST_BUSY 1
`define SRAC_ST_CUST_LOCK 2
`define SRAC_ST_BANK0_BLOCK 3
`define SRAC_ST_REJECT 4
`define SRAC_CTRL_LOCK 0
`define SRAC_CTRL_BURST 1
`define SRAC_CTRL_ACCEL 2
`define SRAC_CTRL_BYPASS 3
`endif
